// >>> common/dls_pkg.sv
// package for the shared lcd/general io port: offsets, reset values, pin map, resource codes
// assumes an 8-bit special function register port and a small segment register file beside it
package dls_pkg;
	localparam logic [7:0] ADDR_PORT0_DATA = 8'h80;
	localparam logic [7:0] ADDR_PORT1_DATA = 8'h90;
	localparam logic [7:0] ADDR_PORT1_DIR = 8'h91;
	localparam logic [7:0] ADDR_PORT2_DATA = 8'hA0;
	localparam logic [7:0] ADDR_PORT2_DIR = 8'hA1;
	localparam logic [7:0] ADDR_PORT0_DIR = 8'hA2;
	localparam logic [7:0] ADDR_PORT3_DATA = 8'hB0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int SEG_DATA_BIT = 0;
	localparam int SEG_DIR_BIT = 3;
	localparam int SFR_DIR_PINS = 24;
	localparam int SFR_DATA_PINS = 32;
	localparam int FIRST_SHARED = 4;
	localparam int RES_W = 3;
	localparam int RES_PINS = 12;
	localparam int OPTICAL_TRANSMIT_PIN_PIN = 2;
	localparam int OPTICAL_RECEIVE_PIN_PIN = 1;
	localparam logic [2:0] RES_NONE = 3'h0;
	localparam logic [2:0] RES_T0 = 3'h2;
	localparam logic [2:0] RES_T1 = 3'h3;
	localparam logic [2:0] RES_INT0_RISE = 3'h4;
	localparam logic [2:0] RES_INT1_RISE = 3'h5;
	localparam logic [2:0] RES_INT0_FALL = 3'h6;
	localparam logic [2:0] RES_INT1_FALL = 3'h7;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dls_sfr_req_t;
	typedef struct packed {
		logic t0;
		logic t1;
		logic int0_rise;
		logic int1_rise;
		logic int0_fall;
		logic int1_fall;
	} dls_res_t;
endpackage

// >>> src/dls_gpio.sv
// shared lcd / general io port: sfr data and direction, segment-register control, pin muxing
// assumes sfr strobes and segment registers are on clock_in; pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
module dls_gpio #(
	parameter int NPINS = 53,
	parameter int NSHARED = 46
) (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire dls_pkg::dls_sfr_req_t sfr_req_in,
	output logic [7:0] sfr_rdata_out,
	input wire logic [NPINS-1:0] segment_select_bit_in,
	input wire logic [NPINS-1:0] seg_data_bit_in,
	input wire logic [NPINS-1:0] seg_dir_bit_in,
	input wire logic [NPINS-1:0] lcd_drive_in,
	input wire logic optical_transmit_pin_en_in,
	input wire logic optical_transmit_data_in,
	input wire logic optical_receive_pin_en_in,
	output logic optical_receive_data_out,
	input wire logic [dls_pkg::RES_PINS*3-1:0] pin_resource_selector_in,
	input wire logic [NPINS-1:0] pad_in,
	output logic [NPINS-1:0] pad_out,
	output logic [NPINS-1:0] pad_oe_n_out,
	output logic [NPINS-1:0] lcd_mode_out,
	output logic [NPINS-1:0] pin_level_out,
	output dls_pkg::dls_res_t resource_out
);
	// =====================================================================
	// sfr registers
	logic [7:0] data_ff [4];
	logic [7:0] dir_ff [3];
	logic [NPINS-1:0] meta_ff, sync_ff;
	logic [7:0] rdata_ff;
	wire logic [3:0] data_hit;
	wire logic [2:0] dir_hit;
	assign data_hit[0] = sfr_req_in.addr == dls_pkg::ADDR_PORT0_DATA;
	assign data_hit[1] = sfr_req_in.addr == dls_pkg::ADDR_PORT1_DATA;
	assign data_hit[2] = sfr_req_in.addr == dls_pkg::ADDR_PORT2_DATA;
	assign data_hit[3] = sfr_req_in.addr == dls_pkg::ADDR_PORT3_DATA;
	assign dir_hit[0] = sfr_req_in.addr == dls_pkg::ADDR_PORT0_DIR;
	assign dir_hit[1] = sfr_req_in.addr == dls_pkg::ADDR_PORT1_DIR;
	assign dir_hit[2] = sfr_req_in.addr == dls_pkg::ADDR_PORT2_DIR;

	genvar r;
	generate
		for (r = 0; r < 4; r++) begin : g_data
			always_ff @(posedge clock_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					data_ff[r] <= dls_pkg::RST_BYTE;
				end else if (sfr_req_in.wr && data_hit[r]) begin
					data_ff[r] <= sfr_req_in.wdata;
				end
			end
		end
		for (r = 0; r < 3; r++) begin : g_dir
			always_ff @(posedge clock_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					dir_ff[r] <= dls_pkg::RST_BYTE;
				end else if (sfr_req_in.wr && dir_hit[r]) begin
					dir_ff[r] <= sfr_req_in.wdata;
				end
			end
		end
	endgenerate

	// =====================================================================
	// pin synchroniser; only the second stage is read
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= pad_in;
			sync_ff <= meta_ff;
		end
	end

	// =====================================================================
	// per-pin control
	wire logic [31:0] sfr_data_flat = {data_ff[3], data_ff[2], data_ff[1], data_ff[0]};
	wire logic [23:0] sfr_dir_flat = {dir_ff[2], dir_ff[1], dir_ff[0]};
	logic [NPINS-1:0] out_val, dir_val, shared, is_lcd, drive;
	genvar p;
	generate
		for (p = 0; p < NPINS; p++) begin : g_pin
			// pins 0..3 and the top dedicated ones have no select bit
			if (p >= dls_pkg::FIRST_SHARED && p < dls_pkg::FIRST_SHARED + NSHARED) begin : g_sh
				assign shared[p] = 1'b1;
			end else begin : g_ded
				assign shared[p] = 1'b0;
			end
			assign is_lcd[p] = shared[p] && segment_select_bit_in[p];
			if (p < dls_pkg::SFR_DATA_PINS) begin : g_sd
				assign out_val[p] = sfr_data_flat[p];
			end else begin : g_rd
				assign out_val[p] = seg_data_bit_in[p];
			end
			if (p < dls_pkg::SFR_DIR_PINS) begin : g_sdir
				assign dir_val[p] = sfr_dir_flat[p];
			end else begin : g_rdir
				assign dir_val[p] = seg_dir_bit_in[p];
			end
			assign drive[p] = dir_val[p];
		end
	endgenerate

	// optical lines take over their pins when enabled
	wire logic tx_take = optical_transmit_pin_en_in;
	wire logic rx_take = optical_receive_pin_en_in;
	logic [NPINS-1:0] nxt_pad, nxt_oe_n;
	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			nxt_pad[i] = is_lcd[i] ? lcd_drive_in[i] : out_val[i];
			nxt_oe_n[i] = !(is_lcd[i] || drive[i]);
		end
		if (tx_take) begin
			nxt_pad[dls_pkg::OPTICAL_TRANSMIT_PIN_PIN] = optical_transmit_data_in;
			nxt_oe_n[dls_pkg::OPTICAL_TRANSMIT_PIN_PIN] = 1'b0;
		end
		if (rx_take) begin
			nxt_oe_n[dls_pkg::OPTICAL_RECEIVE_PIN_PIN] = 1'b1;
		end
	end
	logic [NPINS-1:0] pad_ff, oe_n_ff;
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pad_ff <= '0;
			oe_n_ff <= '1;
		end else begin
			pad_ff <= nxt_pad;
			oe_n_ff <= nxt_oe_n;
		end
	end
	assign pad_out = pad_ff;
	assign pad_oe_n_out = oe_n_ff;
	assign lcd_mode_out = is_lcd;
	assign pin_level_out = sync_ff;
	assign optical_receive_data_out = sync_ff[dls_pkg::OPTICAL_RECEIVE_PIN_PIN];

	// =====================================================================
	// sfr read: data registers return pin levels, direction returns stored bits
	wire logic [31:0] lvl_flat = sync_ff[31:0];
	logic [7:0] nxt_rdata;
	always_comb begin
		nxt_rdata = 8'h00;
		for (int k = 0; k < 4; k++) begin
			if (data_hit[k]) nxt_rdata = lvl_flat[k*8 +: 8];
		end
		for (int k = 0; k < 3; k++) begin
			if (dir_hit[k]) nxt_rdata = dir_ff[k];
		end
	end
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rdata_ff <= 8'h00;
		end else if (sfr_req_in.rd) begin
			rdata_ff <= nxt_rdata;
		end
	end
	assign sfr_rdata_out = rdata_ff;

	// =====================================================================
	// internal resources from the first pins, tracked from the pad level
	dls_res_mux #(.NPINS(dls_pkg::RES_PINS)) u_res (
		.level_in(sync_ff[dls_pkg::RES_PINS-1:0]),
		.sel_in(pin_resource_selector_in),
		.res_out(resource_out)
	);

	// =====================================================================
	// checks
	property p_reset_input;
		@(posedge clock_in) $fell(sys_rst_in) |-> &pad_oe_n_out;
	endproperty
	a_reset_input: assert property (p_reset_input) else $error("pin driven after reset");
	property p_lcd_route;
		@(posedge clock_in) disable iff (sys_rst_in)
		(is_lcd[5] && !tx_take) |=> (pad_out[5] == $past(lcd_drive_in[5]) && !pad_oe_n_out[5]);
	endproperty
	a_lcd_route: assert property (p_lcd_route) else $error("lcd pin not routed");
	property p_dir_zero;
		@(posedge clock_in) disable iff (sys_rst_in)
		(!is_lcd[3] && !dir_val[3]) |=> pad_oe_n_out[3];
	endproperty
	a_dir_zero: assert property (p_dir_zero) else $error("input pin driven");
	property p_dir_write;
		@(posedge clock_in) disable iff (sys_rst_in)
		(sfr_req_in.wr && sfr_req_in.addr == dls_pkg::ADDR_PORT1_DIR) |=> dir_ff[1] == $past(sfr_req_in.wdata);
	endproperty
	a_dir_write: assert property (p_dir_write) else $error("direction write lost");
	sequence s_data_write;
		sfr_req_in.wr && sfr_req_in.addr == dls_pkg::ADDR_PORT0_DATA && !segment_select_bit_in[4];
	endsequence
	property p_data_out;
		@(posedge clock_in) disable iff (sys_rst_in)
		s_data_write ##1 (sfr_req_in == '0) |=> pad_out[4] == $past(sfr_req_in.wdata[4], 2);
	endproperty
	a_data_out: assert property (p_data_out) else $error("data not driven");
	property p_dedicated;
		@(posedge clock_in) disable iff (sys_rst_in) !lcd_mode_out[3] && !lcd_mode_out[0];
	endproperty
	a_dedicated: assert property (p_dedicated) else $error("dedicated pin in lcd mode");
	property p_optical_transmit_pin;
		@(posedge clock_in) disable iff (sys_rst_in)
		tx_take |=> (!pad_oe_n_out[2] && pad_out[2] == $past(optical_transmit_data_in));
	endproperty
	a_optical_transmit_pin: assert property (p_optical_transmit_pin) else $error("optical tx not on pin");
	property p_res_or;
		@(posedge clock_in) disable iff (sys_rst_in)
		(sync_ff[5] && pin_resource_selector_in[17:15] == dls_pkg::RES_T0) |-> resource_out.t0;
	endproperty
	a_res_or: assert property (p_res_or) else $error("resource or missing");
	property p_lcd_ignores;
		@(posedge clock_in) disable iff (sys_rst_in)
		is_lcd[4] |=> !pad_oe_n_out[4];
	endproperty
	a_lcd_ignores: assert property (p_lcd_ignores) else $error("lcd pin follows io dir");
endmodule
`default_nettype wire

// >>> src/dls_res_mux.sv
// per-pin internal resource routing for the shared io port
// assumes pin levels arrive already synchronised to clock_in
`timescale 1ns/1ps
`default_nettype none
module dls_res_mux #(
	parameter int NPINS = 12
) (
	input wire logic [NPINS-1:0] level_in,
	input wire logic [NPINS*3-1:0] sel_in,
	output dls_pkg::dls_res_t res_out
);
	logic [NPINS-1:0] hit_t0, hit_t1, hit_i0r, hit_i1r, hit_i0f, hit_i1f;
	// the selector taps the pad level, so an output pin is tracked too
	genvar g;
	generate
		for (g = 0; g < NPINS; g++) begin : g_pin
			wire logic [2:0] s = sel_in[g*3 +: 3];
			assign hit_t0[g] = level_in[g] && (s == dls_pkg::RES_T0);
			assign hit_t1[g] = level_in[g] && (s == dls_pkg::RES_T1);
			assign hit_i0r[g] = level_in[g] && (s == dls_pkg::RES_INT0_RISE);
			assign hit_i1r[g] = level_in[g] && (s == dls_pkg::RES_INT1_RISE);
			// falling resources get an inverted level so a low pin asserts the line
			assign hit_i0f[g] = !level_in[g] && (s == dls_pkg::RES_INT0_FALL);
			assign hit_i1f[g] = !level_in[g] && (s == dls_pkg::RES_INT1_FALL);
		end
	endgenerate
	// one driver for the whole struct, so no tool sees several continuous writers of one variable
	assign res_out = '{t0: |hit_t0, t1: |hit_t1, int0_rise: |hit_i0r, int1_rise: |hit_i1r,
		int0_fall: |hit_i0f, int1_fall: |hit_i1f};
endmodule
`default_nettype wire

// >>> test/dls_pins_model.sv
// pin-side model: outside drivers on the shared pads
// assumes a pad driven by the port overrides the outside level
`timescale 1ns/1ps
`default_nettype none
module dls_pins_model #(
	parameter int NPINS = 53
) (
	input wire logic [NPINS-1:0] drv_in,
	input wire logic [NPINS-1:0] oe_n_in,
	input wire logic [NPINS-1:0] ext_in,
	output logic [NPINS-1:0] pad_out
);
	// a released pad shows the outside level, never the last driven value
	assign pad_out = (oe_n_in & ext_in) | (~oe_n_in & drv_in);
endmodule
`default_nettype wire

// >>> test/test_dls_gpio.sv
// self-checking bench for the shared lcd / general io port
// assumes pads come from dls_pins_model and sfr strobes last one cycle
`timescale 1ns/1ps
`default_nettype none
module test_dls_gpio;
	localparam int NP = 53;
	logic clock_in = 1'b0;
	logic sys_rst_in = 1'b1;
	dls_pkg::dls_sfr_req_t req = '0;
	logic [7:0] rdata, d, m, x;
	logic [NP-1:0] sel = '0, sdat = '0, sdir = '0, lcd = '0, ext = '0, pin, pout, oen, lmode, plev, q;
	logic tx_en = 1'b0, tx_d = 1'b0, rx_en = 1'b0, rx_d;
	logic [35:0] rsel = '0;
	dls_pkg::dls_res_t res;
	int error_cnt = 0, samples_checked = 0, cyc = 0, k;
	int seed = 32'h2EE8917F;
	logic [7:0] dirs [3] = '{dls_pkg::ADDR_PORT0_DIR, dls_pkg::ADDR_PORT1_DIR, dls_pkg::ADDR_PORT2_DIR};
	logic [7:0] dats [3] = '{dls_pkg::ADDR_PORT0_DATA, dls_pkg::ADDR_PORT1_DATA, dls_pkg::ADDR_PORT2_DATA};
	dls_gpio #(.NPINS(NP), .NSHARED(46)) i_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.sfr_req_in(req), .sfr_rdata_out(rdata), .segment_select_bit_in(sel), .seg_data_bit_in(sdat),
		.seg_dir_bit_in(sdir), .lcd_drive_in(lcd), .optical_transmit_pin_en_in(tx_en),
		.optical_transmit_data_in(tx_d), .optical_receive_pin_en_in(rx_en), .optical_receive_data_out(rx_d),
		.pin_resource_selector_in(rsel), .pad_in(pin), .pad_out(pout), .pad_oe_n_out(oen),
		.lcd_mode_out(lmode), .pin_level_out(plev), .resource_out(res));
	dls_pins_model #(.NPINS(NP)) i_pins (.drv_in(pout), .oe_n_in(oen), .ext_in(ext), .pad_out(pin));
	initial begin
		forever #5 clock_in = ~clock_in;
	end
	// ceiling well above the few hundred cycles the tests need
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			results();
		end
	end
	function automatic logic [7:0] mix(input logic [7:0] dir, input logic [7:0] dat, input logic [7:0] e);
		return (dir & dat) | (~dir & e);
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clock_in);
	endtask
	task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] v);
		req = '{wr: w, rd: ~w, addr: a, wdata: v};
		wt(1);
		req = '0;
		wt(1);
	endtask
	task automatic results;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		wt(10);
		sys_rst_in = 1'b0;
		wt(2);
		chk(oen, {NP{1'b1}});
		for (int i = 0; i < 3; i++) begin
			sfr(1'b0, dirs[i], 8'h00);
			chk(rdata, dls_pkg::RST_BYTE);
		end
		sfr(1'b0, 8'h81, 8'h00);
		chk(rdata, 8'h00);
		$display("test reset done");
		repeat (24) begin
			k = $unsigned($random(seed)) % 3;
			d = 8'($random(seed));
			m = 8'($random(seed));
			x = 8'($random(seed));
			ext[8*k +: 8] = x;
			sfr(1'b1, dirs[k], d);
			sfr(1'b1, dats[k], m);
			wt(5);
			sfr(1'b0, dats[k], 8'h00);
			chk(rdata, mix(d, m, x));
			chk(plev[8*k +: 8], mix(d, m, x));
			sfr(1'b0, dirs[k], 8'h00);
			chk(rdata, d);
			chk(8'(~oen[8*k +: 8]), d);
		end
		$display("test direction and data done");
		sel = {NP{1'b1}};
		lcd = NP'({$random(seed), $random(seed)});
		sfr(1'b1, dls_pkg::ADDR_PORT2_DIR, 8'hFF);
		sfr(1'b1, dls_pkg::ADDR_PORT2_DATA, 8'hFF);
		wt(4);
		chk(lmode, ({NP{1'b1}} >> (NP - 46)) << dls_pkg::FIRST_SHARED);
		chk(pout[23:16], lcd[23:16]);
		q = pout;
		sfr(1'b1, dls_pkg::ADDR_PORT2_DATA, 8'h00);
		wt(4);
		chk(pout[23:16], q[23:16]);
		sel = '0;
		$display("test lcd select done");
		sdir[40] = 1'b1;
		sdat[40] = 1'b1;
		wt(4);
		chk({oen[40], pout[40]}, 2'b01);
		sfr(1'b1, dls_pkg::ADDR_PORT0_DIR, 8'hFF);
		sfr(1'b1, dls_pkg::ADDR_PORT0_DATA, 8'h00);
		tx_en = 1'b1;
		tx_d = 1'b1;
		rx_en = 1'b1;
		ext = '0;
		ext[1] = 1'b1;
		wt(5);
		chk({oen[2], pout[2], oen[1], rx_d}, 4'b0111);
		tx_en = 1'b0;
		rx_en = 1'b0;
		$display("test high pins and optical done");
		sfr(1'b1, dls_pkg::ADDR_PORT0_DIR, 8'h00);
		sfr(1'b1, dls_pkg::ADDR_PORT1_DIR, 8'h00);
		rsel[17:15] = dls_pkg::RES_T0;
		rsel[20:18] = dls_pkg::RES_T0;
		rsel[23:21] = dls_pkg::RES_INT0_FALL;
		rsel[26:24] = dls_pkg::RES_INT1_RISE;
		rsel[29:27] = dls_pkg::RES_T1;
		rsel[32:30] = dls_pkg::RES_INT0_RISE;
		rsel[35:33] = dls_pkg::RES_INT1_FALL;
		ext[7] = 1'b1;
		wt(5);
		chk(res, 6'b000001);
		ext[6] = 1'b1;
		ext[7] = 1'b0;
		wt(5);
		chk(res, 6'b100011);
		ext[6] = 1'b0;
		ext[11:8] = 4'hF;
		sfr(1'b1, dls_pkg::ADDR_PORT0_DIR, 8'h20);
		sfr(1'b1, dls_pkg::ADDR_PORT0_DATA, 8'h20);
		wt(6);
		chk(res, 6'b111110);
		$display("test resources done");
		results();
	end
endmodule
`default_nettype wire
